/* pmg_pkg.sv */
// Shared constants, types and helpers for the port multiplexer block.
package pmg_pkg;

  // Byte-wide bidirectional ports, in index order.
  localparam int NPORT = 10;
  localparam int PW = 8;
  localparam int IW = 4;
  localparam logic [IW-1:0] IDX_P1 = 4'h0;
  localparam logic [IW-1:0] IDX_P2 = 4'h1;
  localparam logic [IW-1:0] IDX_P3 = 4'h2;
  localparam logic [IW-1:0] IDX_P4 = 4'h3;
  localparam logic [IW-1:0] IDX_AH = 4'h4;
  localparam logic [IW-1:0] IDX_DLL = 4'h5;
  localparam logic [IW-1:0] IDX_DLH = 4'h6;
  localparam logic [IW-1:0] IDX_CS = 4'h7;
  localparam logic [IW-1:0] IDX_CT = 4'h8;
  localparam logic [IW-1:0] IDX_CM = 4'h9;

  // Register map: one byte register per port and kind, base plus port index.
  localparam logic [7:0] DATA_BASE = 8'h00;
  localparam logic [7:0] DIR_BASE = 8'h10;
  localparam logic [7:0] MC_BASE = 8'h20;
  localparam logic [7:0] ADDR_PORT0 = 8'h0F;
  localparam logic [7:0] ADDR_P1_FSEL = 8'h30;
  localparam logic [7:0] ADDR_P2_FSEL = 8'h31;

  // Implemented pins of each port, index 9 first.
  localparam logic [NPORT-1:0][PW-1:0] PORT_MASK = {
    8'h1F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h3F};
  localparam logic [PW-1:0] P1_FSEL_MASK = 8'h09;
  localparam logic [PW-1:0] P2_FSEL_MASK = 8'h9E;

  // Reset values.
  localparam logic [PW-1:0] LATCH_RESET = 8'h00;
  localparam logic [PW-1:0] DIR_RESET = 8'hFF;
  localparam logic [PW-1:0] MC_RESET = 8'h00;
  localparam logic [PW-1:0] FSEL_RESET = 8'h00;

  // Bus-control port pin positions.
  localparam int CM_WAIT_BIT = 0;
  localparam int CM_CLKOUT_BIT = 1;
  localparam int CM_HLDAK_BIT = 2;
  localparam int CM_BUS_HOLD_REQUEST_INPUT_BIT = 3;

  typedef enum logic [1:0] {
    PMG_SINGLE_CHIP0,
    PMG_SINGLE_CHIP1,
    PMG_EXT_BOOT0,
    PMG_EXT_BOOT1
  } pmg_boot_t;

  typedef enum logic [1:0] {
    PMG_OP_WRITE,
    PMG_OP_SET,
    PMG_OP_CLEAR,
    PMG_OP_INVERT
  } pmg_bitop_t;

  // Merges a byte write or a single-bit operation into the value read back.
  function automatic logic [PW-1:0] pmg_modify(
    input logic [PW-1:0] old,
    input logic [PW-1:0] wbyte,
    input pmg_bitop_t op,
    input logic [2:0] sel
  );
    logic [PW-1:0] onehot;
    onehot = 8'h01 << sel;
    case (op)
      PMG_OP_SET: pmg_modify = old | onehot;
      PMG_OP_CLEAR: pmg_modify = old & ~onehot;
      PMG_OP_INVERT: pmg_modify = old ^ onehot;
      default: pmg_modify = wbyte;
    endcase
  endfunction

endpackage

/* pmg_port_if.sv */
// Signals between the register core and one byte-wide pin multiplexer.
`timescale 1ns/1ps
interface pmg_port_if;
  logic [7:0] latch;
  logic [7:0] dir;
  logic [7:0] mc;
  logic [7:0] alt_out;
  logic [7:0] alt_drive;
  logic [7:0] pin_in;
  logic [7:0] pin_out;
  logic [7:0] pin_oe_n;
  logic [7:0] rd_val;
  logic [7:0] periph_in;
  modport ctl (
    output latch, dir, mc, alt_out, alt_drive, pin_in,
    input pin_out, pin_oe_n, rd_val, periph_in
  );
  modport mux (
    input latch, dir, mc, alt_out, alt_drive, pin_in,
    output pin_out, pin_oe_n, rd_val, periph_in
  );
endinterface // pmg_port_if

/* pmg_pin_mux.sv */
// Per-pin selection between port latch and peripheral, and the read-back path.
`timescale 1ns/1ps
module pmg_pin_mux
  import pmg_pkg::*;
(
  pmg_port_if.mux pif
);

  genvar b;
  generate
    for (b = 0; b < PW; b++)
    begin : g_bit
      assign pif.pin_oe_n[b] = pif.mc[b] ? ~pif.alt_drive[b] : pif.dir[b];
      assign pif.pin_out[b] = pif.mc[b] ? pif.alt_out[b] : pif.latch[b];
      assign pif.rd_val[b] = pif.dir[b] ? pif.pin_in[b] : (pif.mc[b] ? pif.alt_out[b] : pif.latch[b]);
      assign pif.periph_in[b] = pif.mc[b] & pif.pin_in[b];
    end
  endgenerate

endmodule // pmg_pin_mux

/* pmg_port_mux.sv */
// Port registers, pin multiplexing and read-back for all general-purpose ports.
//
// What this block does
// - Port 0 is eight fixed inputs.
// - Port 0 peripherals always see pins; reads live.
// - Byte and bit access, per-bit direction.
// - Port 1 six bits, bus-control port five; others eight, bidirectional.
// - Port 1 direction, mode and function select.
// - Port mode makes function select ignored.
// - Read gives pin, latch or peripheral output.
// - Bit operations rewrite whole byte from reads.
// - Wide port data usable as 16 or 8.
// - Wide direction 16-bit, halves byte and bit.
// - Wide mode control 16-bit, halves byte and bit.
// - Bus-control port five bits with per-bit direction.
// - Wait and hold request start in control mode, except in single chip 0.
// - Input-pin write updates latch, pin unchanged.
`timescale 1ns/1ps
module pmg_port_mux
  import pmg_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_wide,
  input wire logic [1:0] reg_bitop,
  input wire logic [2:0] reg_bitsel,
  output logic [15:0] reg_rdata,
  input wire logic [1:0] boot_mode,
  input wire logic [7:0] port0_pin_in,
  output logic [7:0] port0_periph_in,
  input wire logic [NPORT*PW-1:0] pin_in,
  input wire logic [NPORT*PW-1:0] alt_out,
  input wire logic [NPORT*PW-1:0] alt_drive,
  output logic [NPORT*PW-1:0] pin_out,
  output logic [NPORT*PW-1:0] pin_oe_n,
  output logic [NPORT*PW-1:0] periph_in,
  output logic [7:0] p1_func_sel,
  output logic [7:0] p2_func_sel
);

  logic [PW-1:0] latch_reg [NPORT];
  logic [PW-1:0] dir_reg [NPORT];
  logic [PW-1:0] mc_reg [NPORT];
  logic [PW-1:0] p1_fsel_reg;
  logic [PW-1:0] p2_fsel_reg;
  logic strap_done_reg;

  logic [PW-1:0] rd_arr [NPORT];
  logic [PW-1:0] dir_vis [NPORT];
  logic [PW-1:0] mc_vis [NPORT];
  logic [NPORT-1:0] data_hit;
  logic [NPORT-1:0] dir_hit;
  logic [NPORT-1:0] mc_hit;
  logic [PW-1:0] data_next [NPORT];
  logic [PW-1:0] dir_next [NPORT];
  logic [PW-1:0] mc_next [NPORT];
  logic [NPORT*PW-1:0] pin_out_next;
  logic [NPORT*PW-1:0] pin_oe_n_next;
  logic [NPORT*PW-1:0] periph_in_next;
  logic [15:0] rdata_next;
  pmg_bitop_t op;

  // A 16-bit access behaves as a plain write; bit operations only reach bytes.
  assign op = reg_wide ? PMG_OP_WRITE : pmg_bitop_t'(reg_bitop);

  pmg_port_if pif [NPORT] ();

  genvar k;
  generate
    for (k = 0; k < NPORT; k++)
    begin : g_port
      logic hi_half;
      logic [PW-1:0] wbyte;

      assign pif[k].latch = latch_reg[k] & PORT_MASK[k];
      assign pif[k].dir = dir_vis[k];
      assign pif[k].mc = mc_vis[k];
      assign pif[k].alt_out = alt_out[k*PW +: PW] & PORT_MASK[k];
      assign pif[k].alt_drive = alt_drive[k*PW +: PW] & PORT_MASK[k];
      assign pif[k].pin_in = pin_in[k*PW +: PW] & PORT_MASK[k];

      pmg_pin_mux u_mux (
        .pif(pif[k])
      );

      assign rd_arr[k] = pif[k].rd_val;
      assign dir_vis[k] = dir_reg[k] | ~PORT_MASK[k];
      assign mc_vis[k] = mc_reg[k] & PORT_MASK[k];
      assign pin_out_next[k*PW +: PW] = pif[k].pin_out & PORT_MASK[k];
      assign pin_oe_n_next[k*PW +: PW] = pif[k].pin_oe_n | ~PORT_MASK[k];
      assign periph_in_next[k*PW +: PW] = pif[k].periph_in;

      assign hi_half = (IW'(k) == IDX_DLH) && reg_wide;
      assign wbyte = hi_half ? reg_wdata[15:8] : reg_wdata[7:0];

      assign data_hit[k] = reg_wr && (hi_half ? (reg_addr == DATA_BASE + 8'(IDX_DLL))
                                              : (reg_addr == DATA_BASE + 8'(k)));
      assign dir_hit[k] = reg_wr && (hi_half ? (reg_addr == DIR_BASE + 8'(IDX_DLL))
                                             : (reg_addr == DIR_BASE + 8'(k)));
      assign mc_hit[k] = reg_wr && (hi_half ? (reg_addr == MC_BASE + 8'(IDX_DLL))
                                            : (reg_addr == MC_BASE + 8'(k)));

      assign data_next[k] = pmg_modify(rd_arr[k], wbyte, op, reg_bitsel);
      assign dir_next[k] = pmg_modify(dir_vis[k], wbyte, op, reg_bitsel);
      assign mc_next[k] = pmg_modify(mc_vis[k], wbyte, op, reg_bitsel);
    end
  endgenerate

  // Boot straps are sampled once, on the first edge after reset release.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      strap_done_reg <= 1'b0;
    else
      strap_done_reg <= 1'b1;
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < NPORT; i++)
        latch_reg[i] <= LATCH_RESET;
    end
    else
    begin
      for (int i = 0; i < NPORT; i++)
        if (data_hit[i])
          latch_reg[i] <= data_next[i] & PORT_MASK[i];
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < NPORT; i++)
        dir_reg[i] <= DIR_RESET;
    end
    else
    begin
      for (int i = 0; i < NPORT; i++)
        if (dir_hit[i])
          dir_reg[i] <= dir_next[i] | ~PORT_MASK[i];
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < NPORT; i++)
        mc_reg[i] <= MC_RESET;
    end
    else if (!strap_done_reg)
    begin
      if (pmg_boot_t'(boot_mode) != PMG_SINGLE_CHIP0)
      begin
        mc_reg[IDX_CM][CM_WAIT_BIT] <= 1'b1;
        mc_reg[IDX_CM][CM_BUS_HOLD_REQUEST_INPUT_BIT] <= 1'b1;
      end
    end
    else
    begin
      for (int i = 0; i < NPORT; i++)
        if (mc_hit[i])
          mc_reg[i] <= mc_next[i] & PORT_MASK[i];
    end
  end

  // port 1 keeps only bits 0 and 3, port 2 bits 1 to 4 and 7
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      p1_fsel_reg <= FSEL_RESET;
      p2_fsel_reg <= FSEL_RESET;
    end
    else if (reg_wr && !reg_wide)
    begin
      if (reg_addr == ADDR_P1_FSEL)
        p1_fsel_reg <= pmg_modify(p1_fsel_reg, reg_wdata[7:0], op, reg_bitsel) & P1_FSEL_MASK;
      if (reg_addr == ADDR_P2_FSEL)
        p2_fsel_reg <= pmg_modify(p2_fsel_reg, reg_wdata[7:0], op, reg_bitsel) & P2_FSEL_MASK;
    end
  end

  // Read decode; unmapped addresses return zero.
  always_comb
  begin
    rdata_next = 16'h0000;
    if (reg_addr == ADDR_PORT0)
      rdata_next[7:0] = port0_pin_in;
    else if (reg_addr == ADDR_P1_FSEL)
      rdata_next[7:0] = p1_fsel_reg;
    else if (reg_addr == ADDR_P2_FSEL)
      rdata_next[7:0] = p2_fsel_reg;
    else
    begin
      for (int i = 0; i < NPORT; i++)
      begin
        if (reg_addr == DATA_BASE + 8'(i))
          rdata_next[7:0] = rd_arr[i] & PORT_MASK[i];
        if (reg_addr == DIR_BASE + 8'(i))
          rdata_next[7:0] = dir_vis[i];
        if (reg_addr == MC_BASE + 8'(i))
          rdata_next[7:0] = mc_vis[i];
      end
      if (reg_wide && reg_addr == DATA_BASE + 8'(IDX_DLL))
        rdata_next[15:8] = rd_arr[IDX_DLH];
      if (reg_wide && reg_addr == DIR_BASE + 8'(IDX_DLL))
        rdata_next[15:8] = dir_vis[IDX_DLH];
      if (reg_wide && reg_addr == MC_BASE + 8'(IDX_DLL))
        rdata_next[15:8] = mc_vis[IDX_DLH];
    end
  end

  // Read data stands for exactly the cycle after the strobe.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
      reg_rdata <= rdata_next;
    else
      reg_rdata <= 16'h0000;
  end

  // Pins are registered; the peripheral path is one cycle late as a result.
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pin_out <= '0;
      pin_oe_n <= '1;
      periph_in <= '0;
    end
    else
    begin
      pin_out <= pin_out_next;
      pin_oe_n <= pin_oe_n_next;
      periph_in <= periph_in_next;
    end
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      port0_periph_in <= 8'h00;
    else
      port0_periph_in <= port0_pin_in;
  end

  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      p1_func_sel <= 8'h00;
      p2_func_sel <= 8'h00;
    end
    else
    begin
      p1_func_sel <= p1_fsel_reg & mc_vis[IDX_P1];
      p2_func_sel <= p2_fsel_reg & mc_vis[IDX_P2];
    end
  end

endmodule // pmg_port_mux

/* pmg_pin_world.sv */
// Pin-side model: the outside world behind every bidirectional pin.
`timescale 1ns/1ps
module pmg_pin_world
  import pmg_pkg::*;
#(
  parameter logic CM_IDLE = 1'b1
)
(
  input wire logic [NPORT*PW-1:0] pin_out,
  input wire logic [NPORT*PW-1:0] pin_oe_n,
  input wire logic [NPORT*PW-1:0] ext_level,
  output logic [NPORT*PW-1:0] pin_in
);
  logic [NPORT*PW-1:0] outside;
  always_comb
  begin
    outside = ext_level;
    outside[PW*int'(IDX_CM)+CM_WAIT_BIT] = CM_IDLE;
    outside[PW*int'(IDX_CM)+CM_BUS_HOLD_REQUEST_INPUT_BIT] = CM_IDLE;
  end
  // A driven pin shows the block's level, so a wrong enable shows up in read-back.
  assign pin_in = (pin_out & ~pin_oe_n) | (outside & pin_oe_n);
endmodule // pmg_pin_world

/* pmg_port_mux_sva.sv */
// Port-level checks for the port multiplexer.
`timescale 1ns/1ps
module pmg_port_mux_sva
  import pmg_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [1:0] boot_mode,
  input wire logic [7:0] port0_pin_in,
  input wire logic [7:0] port0_periph_in,
  input wire logic [NPORT*PW-1:0] pin_in,
  input wire logic [NPORT*PW-1:0] alt_drive,
  input wire logic [NPORT*PW-1:0] pin_out,
  input wire logic [NPORT*PW-1:0] pin_oe_n,
  input wire logic [NPORT*PW-1:0] periph_in,
  input wire logic [7:0] p1_func_sel,
  input wire logic [7:0] p2_func_sel
);
  // Counts edges since reset release; the strap result is visible at the third.
  logic [1:0] cyc_reg;
  always_ff @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      cyc_reg <= 2'h0;
    else if (cyc_reg != 2'h3)
      cyc_reg <= cyc_reg + 2'h1;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data without a read");
  a_reset_quiet: assert property (!$past(rstn) |-> &pin_oe_n && pin_out == '0 && periph_in == '0)
    else $error("pins not idle after reset");
  a_unused_off: assert property (pin_oe_n[7:6] == 2'h3 && pin_oe_n[79:77] == 3'h7)
    else $error("missing pin driven");
  a_input_copy: assert property ($past(rstn) |-> port0_periph_in == $past(port0_pin_in))
    else $error("input port not passed on");
  a_fsel1_bits: assert property ((p1_func_sel & 8'hF6) == 8'h00)
    else $error("port 1 select bit out of range");
  a_fsel2_bits: assert property ((p2_func_sel & 8'h61) == 8'h00)
    else $error("port 2 select bit out of range");
  a_periph_echo: assert property ($past(rstn) |-> (periph_in & ~$past(pin_in)) == '0)
    else $error("peripheral sees a level not on the pin");
  a_boot_ctl: assert property (cyc_reg == 2'h2 && boot_mode != 2'h0 |->
    periph_in[72] == $past(pin_in[72]) && periph_in[75] == $past(pin_in[75])
    && pin_oe_n[72] == !$past(alt_drive[72]))
    else $error("strobes not in control mode after boot");
  a_boot_port: assert property (cyc_reg == 2'h2 && boot_mode == 2'h0 |-> !periph_in[72] && !periph_in[75])
    else $error("strobe in control mode in single chip 0");
  c_read: cover property (reg_rd);
  c_boot: cover property (cyc_reg == 2'h2 && boot_mode == 2'h3);
  c_fsel: cover property (p1_func_sel != 8'h00);
endmodule // pmg_port_mux_sva

bind pmg_port_mux pmg_port_mux_sva pmg_port_mux_sva_inst (.core_clk, .rstn, .reg_rd, .reg_rdata,
  .boot_mode, .port0_pin_in, .port0_periph_in, .pin_in, .alt_drive, .pin_out, .pin_oe_n, .periph_in,
  .p1_func_sel, .p2_func_sel);

/* tb.sv */
// Self-checking bench for the port multiplexer.
`timescale 1ns/1ps
module tb
  import pmg_pkg::*;
;
  typedef struct packed {logic wr; logic [7:0] a; logic [15:0] d; logic w; logic [15:0] e;} pmg_row_t;
  localparam pmg_row_t ROWS [16] = '{
    '{1, 8'h10, 16'h00C5, 0, 16'h00C5}, '{1, 8'h20, 16'h002A, 0, 16'h002A},
    '{1, 8'h30, 16'h0009, 0, 16'h0009}, '{1, 8'h31, 16'h009E, 0, 16'h009E},
    '{1, 8'h18, 16'h005A, 0, 16'h005A}, '{1, 8'h23, 16'h00A5, 0, 16'h00A5},
    '{1, 8'h19, 16'h00F3, 0, 16'h00F3}, '{1, 8'h15, 16'h3C5A, 1, 16'h3C5A},
    '{1, 8'h16, 16'h0081, 0, 16'h0081}, '{0, 8'h15, 16'h0000, 1, 16'h815A},
    '{1, 8'h15, 16'h0000, 1, 16'h0000}, '{1, 8'h05, 16'h1234, 1, 16'h1234},
    '{0, 8'h06, 16'h0000, 0, 16'h0012}, '{1, 8'h25, 16'hA55A, 1, 16'hA55A},
    '{0, 8'h26, 16'h0000, 0, 16'h00A5}, '{1, 8'h3F, 16'h00FF, 0, 16'h0000}};
  logic core_clk, rstn, reg_wr, reg_rd, reg_wide;
  logic [7:0] reg_addr, port0_pin_in, port0_periph_in, p1_func_sel, p2_func_sel, lat, v;
  logic [15:0] reg_wdata, reg_rdata;
  logic [1:0] reg_bitop, boot_mode;
  logic [2:0] reg_bitsel;
  logic [NPORT*PW-1:0] pin_in, alt_out, alt_drive, pin_out, pin_oe_n, periph_in, ext_level;
  int n_fail, checked, cycles;

  pmg_port_mux pmg_port_mux_inst (.core_clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_wide,
    .reg_bitop, .reg_bitsel, .reg_rdata, .boot_mode, .port0_pin_in, .port0_periph_in, .pin_in, .alt_out,
    .alt_drive, .pin_out, .pin_oe_n, .periph_in, .p1_func_sel, .p2_func_sel);
  pmg_pin_world pmg_pin_world_inst (.pin_out, .pin_oe_n, .ext_level, .pin_in);

  task automatic report_and_stop;
    if (n_fail == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error %0t: saw %h, wanted %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic w = 0, input logic [1:0] op = 0,
    input logic [2:0] s = 0);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    reg_wide <= w;
    reg_bitop <= op;
    reg_bitsel <= s;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic w = 0);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    reg_wide <= w;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // Outputs follow the registers one edge later; the second edge leaves margin.
  task automatic settle;
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  task automatic do_reset(input logic [1:0] b);
    @(posedge core_clk);
    rstn <= 1'b0;
    boot_mode <= b;
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles > 3000)
    begin
      n_fail++;
      report_and_stop();
    end
  end

  initial
  begin
    {rstn, reg_wr, reg_rd, reg_wide, reg_addr, reg_wdata, reg_bitop, reg_bitsel, boot_mode} = '0;
    port0_pin_in = 8'h5A;
    ext_level = 80'h3C << 16;
    alt_out = {10{8'h66}};
    alt_drive = 80'hF0 << 16;
    do_reset(2'h0);
    rd(8'h10, {8'h00, DIR_RESET});
    chk({15'h0000, &pin_oe_n}, 16'h0001);
    foreach (ROWS[i])
    begin
      if (ROWS[i].wr)
        wr(ROWS[i].a, ROWS[i].d, ROWS[i].w);
      rd(ROWS[i].a, ROWS[i].e, ROWS[i].w);
    end
    settle();
    chk({p1_func_sel, p2_func_sel}, 16'h0800);
    wr(8'h21, 16'h000E);
    settle();
    chk({8'h00, p2_func_sel}, 16'h000E);
    wr(8'h02, 16'h00A5);
    rd(8'h02, 16'h003C);
    wr(8'h12, 16'h0000);
    rd(8'h02, 16'h00A5);
    settle();
    chk({pin_oe_n[23:16], pin_out[23:16]}, 16'h00A5);
    wr(8'h22, 16'h00F0);
    rd(8'h02, 16'h0065);
    settle();
    chk({pin_oe_n[23:16], pin_out[23:16]}, 16'h0065);
    chk({8'h00, periph_in[23:16]}, 16'h0060);
    wr(8'h22, 16'h0000);
    wr(8'h12, 16'h000F);
    lat = 8'hA5;
    for (int op = 1; op < 4; op++)
    begin
      v = {lat[7:4], 4'hC};
      lat = (op == 1) ? (v | 8'h20) : (op == 2) ? (v & 8'hDF) : (v ^ 8'h20);
      wr(8'h02, 16'h0000, 1'b0, op[1:0], 3'h5);
      rd(8'h02, {8'h00, lat[7:4], 4'hC});
    end
    wr(8'h12, 16'h0000);
    rd(8'h02, {8'h00, lat});
    // A wide access must ignore the bit operation and act as a plain write.
    wr(8'h15, 16'h0102, 1'b1, 2'h1, 3'h0);
    rd(8'h15, 16'h0102, 1'b1);
    wr(8'h16, 16'h0000, 1'b0, 2'h1, 3'h7);
    rd(8'h15, 16'h8102, 1'b1);
    wr(8'h25, 16'h0000, 1'b0, 2'h3, 3'h0);
    rd(8'h25, 16'hA55B, 1'b1);
    wr(8'h26, 16'h0000, 1'b0, 2'h2, 3'h7);
    rd(8'h26, 16'h0025);
    wr(8'h0F, 16'h0000);
    rd(8'h0F, 16'h005A);
    chk({8'h00, port0_periph_in}, 16'h005A);
    for (int b = 0; b < 4; b++)
    begin
      do_reset(b[1:0]);
      rd(8'h29, (b == 0) ? 16'h0000 : 16'h0009);
      rd(8'h12, {8'h00, DIR_RESET});
    end
    report_and_stop();
  end
endmodule // tb
